// >>> design/led_flash_pkg.sv
// Constants, register map and timing for the LED sink flash control block.
// Assumes a 250 MHz clock; all flash and ramp timing runs on a 1 us tick.
package led_flash_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLOCK_PERIOD_NS = 4;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYCLES = (TICK_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int TICK_W = 12;
    localparam int US_PER_MS = 1000;
    localparam int US_PER_S = 1000 * US_PER_MS;
    localparam int DUR_0_US = 32 * US_PER_MS;
    localparam int DUR_1_US = 64 * US_PER_MS;
    localparam int DUR_2_US = 96 * US_PER_MS;
    localparam int DUR_3_US = 1024 * US_PER_MS;
    localparam int REPEAT_US = 4 * US_PER_S;
    localparam int RAMP_LED_1_US = US_PER_S / 4;
    localparam int RAMP_LED_2_US = US_PER_S / 2;
    localparam int RAMP_LED_3_US = US_PER_S;
    localparam int RAMP_FL_1_US = 1950;
    localparam int RAMP_FL_2_US = 3910;
    localparam int RAMP_FL_3_US = 7800;
    localparam int RAMP_STEPS = 256;
    localparam int DUR_W = 20;
    localparam int REP_W = 22;
    localparam int STEP_W = 12;
    localparam int LEVEL_W = 8;
    localparam logic [LEVEL_W-1:0] LEVEL_MAX = 8'hff;

    // ****************************************
    // Register map (word index, byte address is four times it)
    // ****************************************
    localparam int ADDR_W = 10;
    localparam logic [7:0] IDX_POWER_ENABLE = 8'h0e;
    localparam logic [7:0] IDX_A_CURRENT = 8'hac;
    localparam logic [7:0] IDX_A_CTRL = 8'had;
    localparam logic [7:0] IDX_B_CURRENT = 8'hae;
    localparam logic [7:0] IDX_B_CTRL = 8'haf;
    localparam int BIT_FUNC = 15;
    localparam int BIT_TRIG = 14;
    localparam int BIT_DRIVE = 13;
    localparam int BIT_RPT = 12;
    localparam int DUR_LO = 8;
    localparam int OFF_LO = 4;
    localparam int ON_LO = 0;
    localparam int BIT_CUR_ENA = 15;
    localparam int BIT_CUR_HIB = 12;
    localparam logic [15:0] CTRL_WRITE_MASK = 16'hf333;
    localparam logic [15:0] CTRL_RESET = 16'h0000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BURST = 2'b10
    } burst_state_t;

    function automatic logic [DUR_W-1:0] flash_dur_us(input logic [1:0] code);
        case (code)
            2'b00: flash_dur_us = DUR_W'(DUR_0_US);
            2'b01: flash_dur_us = DUR_W'(DUR_1_US);
            2'b10: flash_dur_us = DUR_W'(DUR_2_US);
            default: flash_dur_us = DUR_W'(DUR_3_US);
        endcase
    endfunction

    // Length of one level step; code 00 is instant and never counted
    function automatic logic [STEP_W-1:0] ramp_step_us(input logic flash, input logic [1:0] code);
        case ({flash, code})
            3'b001: ramp_step_us = STEP_W'(RAMP_LED_1_US / RAMP_STEPS);
            3'b010: ramp_step_us = STEP_W'(RAMP_LED_2_US / RAMP_STEPS);
            3'b011: ramp_step_us = STEP_W'(RAMP_LED_3_US / RAMP_STEPS);
            3'b101: ramp_step_us = STEP_W'(RAMP_FL_1_US / RAMP_STEPS);
            3'b110: ramp_step_us = STEP_W'(RAMP_FL_2_US / RAMP_STEPS);
            3'b111: ramp_step_us = STEP_W'(RAMP_FL_3_US / RAMP_STEPS);
            default: ramp_step_us = STEP_W'(1);
        endcase
    endfunction

    function automatic logic [7:0] ctrl_index(input int ch);
        ctrl_index = (ch == 0) ? IDX_A_CTRL : IDX_B_CTRL;
    endfunction

    function automatic logic [7:0] current_index(input int ch);
        current_index = (ch == 0) ? IDX_A_CURRENT : IDX_B_CURRENT;
    endfunction

endpackage

// >>> design/led_sink_flash_control.sv
// Flash and ramp control for two constant-current LED sinks.
// Assumes an Avalon-MM master on the same clock, asynchronous GPIO
// trigger pins, and a hibernate level from the same clock domain.
//
// Notes on behaviour
// [RULE1] Two identical independent sink channels
// [RULE2] Bit 15 selects LED or flash
// [RULE3] LED mode conducts while drive bit set
// [RULE4] Repeat bit flashes automatically every 4 s
// [RULE5] Otherwise exactly one flash per trigger
// [RULE6] Bit 14 picks register or GPIO trigger
// [RULE7] Trigger source ignored in LED mode
// [RULE8] GPIO trigger acts on edge only
// [RULE9] Drive write starts flash, self-clears at end
// [RULE10] With GPIO trigger, drive writes do nothing
// [RULE11] Bits 9:8 set 32/64/96/1024 ms
// [RULE12] Duration applies to every flash
// [RULE13] Drive bit reads live on/off status
// [RULE14] Sink conducts only when channel enabled
// [RULE15] Hibernate exit clears both drive bits
// [RULE16] Host rewrites drive after hibernate exit
// [RULE17] Bits 5:4 set mode-dependent off ramp
// [RULE18] Bits 1:0 set on ramp likewise
// [RULE19] Enable bits reachable at two locations
// [RULE20] Current register bit 12 keeps sink in hibernate
// [RULE21] Triggers during a flash are ignored
// [RULE22] All timing from one tick counter
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps

module led_sink_flash_control #(
    parameter int TICK_CYCLES = led_flash_pkg::TICK_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [led_flash_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic flash_trigger_a,
    input wire logic flash_trigger_b,
    input wire logic hibernate,
    output logic sink_pin_a_on,
    output logic [led_flash_pkg::LEVEL_W-1:0] sink_pin_a_level,
    output logic sink_pin_b_on,
    output logic [led_flash_pkg::LEVEL_W-1:0] sink_pin_b_level
);

    // ****************************************
    // Declarations
    // ****************************************
    logic [led_flash_pkg::TICK_W-1:0] tick_count;
    logic tick;
    logic [7:0] reg_idx;
    logic write_fire;
    logic power_wr;
    logic hib_prev;
    logic hib_exit;
    logic [1:0] trig_pin;
    logic [15:0] ctrl [2];
    logic [15:0] next_ctrl [2];
    logic [1:0] ctrl_wr;
    logic [1:0] cur_wr;
    logic [1:0] chan_ena;
    logic [1:0] hib_keep;
    logic [1:0] drive_rise;
    logic [1:0] status;
    logic [1:0] trig_meta;
    logic [1:0] trig_sync;
    logic [1:0] trig_prev;
    logic [1:0] gpio_edge;
    logic [1:0] repeat_fire;
    logic [1:0] trigger;
    logic [1:0] burst_end;
    logic [1:0] want_on;
    logic [1:0] sink_on;
    logic [led_flash_pkg::REP_W-1:0] repeat_cnt [2];
    logic [led_flash_pkg::DUR_W-1:0] burst_cnt [2];
    logic [led_flash_pkg::STEP_W-1:0] ramp_cnt [2];
    logic [led_flash_pkg::LEVEL_W-1:0] level [2];
    led_flash_pkg::burst_state_t state [2];
    logic [31:0] next_readdata;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wdata,
                                             input logic [1:0] be);
        merge16 = {be[1] ? wdata[15:8] : old[15:8], be[0] ? wdata[7:0] : old[7:0]};
    endfunction

    // ****************************************
    // Time base
    // ****************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tick_count <= 12'h000;
            tick <= 1'b0;
        end else if (tick_count == led_flash_pkg::TICK_W'(TICK_CYCLES - 1)) begin
            tick_count <= 12'h000; // see [RULE22]
            tick <= 1'b1;
        end else begin
            tick_count <= tick_count + 12'h001;
            tick <= 1'b0;
        end
    end

    // ****************************************
    // Avalon-MM slave
    // ****************************************
    assign reg_idx = address[led_flash_pkg::ADDR_W-1:2];
    assign write_fire = write && !waitrequest;
    assign power_wr = write_fire && byteenable[0] && (reg_idx == led_flash_pkg::IDX_POWER_ENABLE);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            waitrequest <= 1'b1;
        end else if ((read || write) && waitrequest) begin
            waitrequest <= 1'b0;
        end else begin
            waitrequest <= 1'b1;
        end
    end

    always_comb begin
        next_readdata = 32'h0000_0000;
        case (reg_idx)
            led_flash_pkg::IDX_POWER_ENABLE: begin
                next_readdata[1:0] = chan_ena;
            end
            led_flash_pkg::IDX_A_CURRENT, led_flash_pkg::IDX_B_CURRENT: begin
                next_readdata[led_flash_pkg::BIT_CUR_ENA] = chan_ena[reg_idx[1]];
                next_readdata[led_flash_pkg::BIT_CUR_HIB] = hib_keep[reg_idx[1]];
            end
            led_flash_pkg::IDX_A_CTRL, led_flash_pkg::IDX_B_CTRL: begin
                next_readdata[15:0] = ctrl[reg_idx[1]];
                next_readdata[led_flash_pkg::BIT_DRIVE] = status[reg_idx[1]]; // see [RULE13]
            end
            default: begin
                next_readdata = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            readdata <= 32'h0000_0000;
        end else if (read && waitrequest) begin
            readdata <= next_readdata;
        end
    end

    // ****************************************
    // Hibernate exit
    // ****************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hib_prev <= 1'b0;
        end else begin
            hib_prev <= hibernate;
        end
    end

    assign hib_exit = hib_prev && !hibernate;
    assign trig_pin = {flash_trigger_b, flash_trigger_a};

    // ****************************************
    // Sink channels
    // ****************************************
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan // see [RULE1]
        logic flash_mode;
        logic use_gpio;
        logic auto_rpt;
        logic [led_flash_pkg::LEVEL_W-1:0] target;
        logic [led_flash_pkg::STEP_W-1:0] step_len;

        assign flash_mode = ctrl[ch][led_flash_pkg::BIT_FUNC]; // see [RULE2]
        assign use_gpio = ctrl[ch][led_flash_pkg::BIT_TRIG];
        assign auto_rpt = ctrl[ch][led_flash_pkg::BIT_RPT];
        assign ctrl_wr[ch] = write_fire && (reg_idx == led_flash_pkg::ctrl_index(ch));
        assign cur_wr[ch] = write_fire && (reg_idx == led_flash_pkg::current_index(ch));

        // Control register; a software write wins over a hardware clear
        always_comb begin
            next_ctrl[ch] = ctrl[ch];
            if (hib_exit) begin
                next_ctrl[ch][led_flash_pkg::BIT_DRIVE] = 1'b0; // see [RULE15]
            end
            if (burst_end[ch] && !use_gpio) begin
                next_ctrl[ch][led_flash_pkg::BIT_DRIVE] = 1'b0; // see [RULE9]
            end
            if (ctrl_wr[ch]) begin
                next_ctrl[ch] = merge16(next_ctrl[ch], writedata[15:0], byteenable[1:0])
                                & led_flash_pkg::CTRL_WRITE_MASK;
            end
        end

        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                ctrl[ch] <= led_flash_pkg::CTRL_RESET;
            end else begin
                ctrl[ch] <= next_ctrl[ch];
            end
        end

        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                drive_rise[ch] <= 1'b0;
            end else begin
                drive_rise[ch] <= ctrl_wr[ch] && byteenable[1] && writedata[led_flash_pkg::BIT_DRIVE]
                                  && !ctrl[ch][led_flash_pkg::BIT_DRIVE];
            end
        end

        // Enable is shared by the power register and the current register
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                chan_ena[ch] <= 1'b0;
                hib_keep[ch] <= 1'b0;
            end else if (cur_wr[ch] && byteenable[1]) begin
                chan_ena[ch] <= writedata[led_flash_pkg::BIT_CUR_ENA]; // see [RULE19]
                hib_keep[ch] <= writedata[led_flash_pkg::BIT_CUR_HIB]; // see [RULE20]
            end else if (power_wr) begin
                chan_ena[ch] <= writedata[ch]; // see [RULE19]
            end
        end

        // Trigger pin synchroniser and rising edge detect
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                trig_meta[ch] <= 1'b0;
                trig_sync[ch] <= 1'b0;
                trig_prev[ch] <= 1'b0;
            end else begin
                trig_meta[ch] <= trig_pin[ch];
                trig_sync[ch] <= trig_meta[ch];
                trig_prev[ch] <= trig_sync[ch];
            end
        end

        assign gpio_edge[ch] = trig_sync[ch] && !trig_prev[ch]; // see [RULE8]

        // Automatic repeat timer
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                repeat_cnt[ch] <= 22'h00_0000;
            end else if (!(flash_mode && auto_rpt)) begin
                repeat_cnt[ch] <= 22'h00_0000;
            end else if (tick) begin
                repeat_cnt[ch] <= repeat_fire[ch] ? 22'h00_0000 : repeat_cnt[ch] + 22'h00_0001;
            end
        end

        assign repeat_fire[ch] = tick && flash_mode && auto_rpt
                                 && (repeat_cnt[ch] == led_flash_pkg::REP_W'(led_flash_pkg::REPEAT_US - 1));

        // One trigger source at a time, and only in flash mode
        always_comb begin
            if (!flash_mode) begin
                trigger[ch] = 1'b0; // see [RULE7]
            end else if (auto_rpt) begin
                trigger[ch] = repeat_fire[ch]; // see [RULE4]
            end else if (use_gpio) begin
                trigger[ch] = gpio_edge[ch]; // see [RULE6] [RULE10]
            end else begin
                trigger[ch] = drive_rise[ch]; // see [RULE5] [RULE9]
            end
        end

        assign burst_end[ch] = (state[ch] == led_flash_pkg::ST_BURST) && tick
                               && (burst_cnt[ch] == led_flash_pkg::flash_dur_us(ctrl[ch][9:8]) - 20'h0_0001);

        // Flash sequencer
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                state[ch] <= led_flash_pkg::ST_IDLE;
                burst_cnt[ch] <= 20'h0_0000;
            end else begin
                case (state[ch])
                    led_flash_pkg::ST_IDLE: begin
                        burst_cnt[ch] <= 20'h0_0000;
                        if (trigger[ch]) begin
                            state[ch] <= led_flash_pkg::ST_BURST;
                        end
                    end
                    led_flash_pkg::ST_BURST: begin
                        if (!flash_mode || burst_end[ch]) begin
                            state[ch] <= led_flash_pkg::ST_IDLE; // see [RULE11] [RULE12]
                            burst_cnt[ch] <= 20'h0_0000;
                        end else if (tick) begin
                            burst_cnt[ch] <= burst_cnt[ch] + 20'h0_0001; // see [RULE21]
                        end
                    end
                    default: begin
                        state[ch] <= led_flash_pkg::ST_IDLE;
                        burst_cnt[ch] <= 20'h0_0000;
                    end
                endcase
            end
        end

        assign status[ch] = flash_mode ? (state[ch] == led_flash_pkg::ST_BURST)
                                       : ctrl[ch][led_flash_pkg::BIT_DRIVE];

        // Conduction request
        always_comb begin
            want_on[ch] = status[ch]; // see [RULE3]
            if (!chan_ena[ch]) begin
                want_on[ch] = 1'b0; // see [RULE14]
            end
            if (hibernate && !hib_keep[ch]) begin
                want_on[ch] = 1'b0; // see [RULE20]
            end
        end

        assign target = want_on[ch] ? led_flash_pkg::LEVEL_MAX : 8'h00;
        assign step_len = want_on[ch]
            ? led_flash_pkg::ramp_step_us(flash_mode, ctrl[ch][led_flash_pkg::ON_LO+:2])
            : led_flash_pkg::ramp_step_us(flash_mode, ctrl[ch][led_flash_pkg::OFF_LO+:2]);

        // Current ramp
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                level[ch] <= 8'h00;
                ramp_cnt[ch] <= 12'h000;
                sink_on[ch] <= 1'b0;
            end else begin
                sink_on[ch] <= want_on[ch];
                if (!chan_ena[ch] || level[ch] == target) begin
                    level[ch] <= chan_ena[ch] ? level[ch] : 8'h00;
                    ramp_cnt[ch] <= 12'h000;
                end else if (want_on[ch] && ctrl[ch][led_flash_pkg::ON_LO+:2] == 2'b00) begin
                    level[ch] <= target; // see [RULE18]
                end else if (!want_on[ch] && ctrl[ch][led_flash_pkg::OFF_LO+:2] == 2'b00) begin
                    level[ch] <= target; // see [RULE17]
                end else if (tick) begin
                    if (ramp_cnt[ch] >= step_len - 12'h001) begin
                        ramp_cnt[ch] <= 12'h000;
                        level[ch] <= want_on[ch] ? level[ch] + 8'h01 : level[ch] - 8'h01; // see [RULE17] [RULE18]
                    end else begin
                        ramp_cnt[ch] <= ramp_cnt[ch] + 12'h001;
                    end
                end
            end
        end

        // ****************************************
        // Checks
        // ****************************************
        a_ena_gates_sink: assert property (@(posedge clock) disable iff (rst) // see [RULE14]
            !chan_ena[ch] |=> !sink_on[ch] && level[ch] == 8'h00)
            else $error("sink conducts while disabled");

        a_led_drive_on: assert property (@(posedge clock) disable iff (rst) // see [RULE3]
            !flash_mode && ctrl[ch][led_flash_pkg::BIT_DRIVE] && chan_ena[ch] && !hibernate
            |=> sink_on[ch])
            else $error("led mode drive not followed");

        a_hib_exit_clear: assert property (@(posedge clock) disable iff (rst) // see [RULE15]
            hib_exit && !ctrl_wr[ch] |=> !ctrl[ch][led_flash_pkg::BIT_DRIVE])
            else $error("drive bit kept after hibernate exit");

        a_burst_self_clear: assert property (@(posedge clock) disable iff (rst) // see [RULE9]
            burst_end[ch] && !use_gpio && !ctrl_wr[ch]
            |=> !ctrl[ch][led_flash_pkg::BIT_DRIVE] && state[ch] == led_flash_pkg::ST_IDLE)
            else $error("drive bit not cleared at flash end");

        a_burst_ignores_trig: assert property (@(posedge clock) disable iff (rst) // see [RULE21]
            state[ch] == led_flash_pkg::ST_BURST && flash_mode && !burst_end[ch]
            |=> state[ch] == led_flash_pkg::ST_BURST && burst_cnt[ch] >= $past(burst_cnt[ch]))
            else $error("flash cut short by a new trigger");

        a_burst_length: assert property (@(posedge clock) disable iff (rst) // see [RULE11]
            state[ch] == led_flash_pkg::ST_BURST
            |-> burst_cnt[ch] < led_flash_pkg::flash_dur_us(ctrl[ch][9:8]))
            else $error("flash longer than programmed");

        a_gpio_blocks_reg: assert property (@(posedge clock) disable iff (rst) // see [RULE10]
            flash_mode && use_gpio && !auto_rpt && !gpio_edge[ch]
            && state[ch] == led_flash_pkg::ST_IDLE |=> state[ch] == led_flash_pkg::ST_IDLE)
            else $error("flash started without gpio edge");

        a_led_no_burst: assert property (@(posedge clock) disable iff (rst) // see [RULE7]
            !flash_mode && state[ch] == led_flash_pkg::ST_IDLE |=> state[ch] == led_flash_pkg::ST_IDLE)
            else $error("flash started in led mode");
    end

    a_wait_answer: assert property (@(posedge clock) disable iff (rst)
        (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("waitrequest not a single low cycle");

    assign sink_pin_a_on = sink_on[0];
    assign sink_pin_b_on = sink_on[1];
    assign sink_pin_a_level = level[0];
    assign sink_pin_b_level = level[1];

endmodule

// >>> testbench/flash_pin_source.sv
// GPIO flash trigger pins as driven by the host side.
// Assumes the bench clock; the pins follow the bench's level request one cycle later.
`timescale 1ns/1ps

module flash_pin_source (
    input wire logic clock,
    input wire logic rst,
    input wire logic [1:0] level_req,
    output logic pin_a,
    output logic pin_b
);
    // ****************************************
    // Pin levels
    // ****************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_a <= 1'b0;
            pin_b <= 1'b0;
        end else begin
            pin_a <= level_req[0];
            pin_b <= level_req[1];
        end
    end
endmodule

// >>> testbench/led_sink_flash_control_test.sv
// Self-checking bench for the LED sink flash control block.
// Assumes the design package, the pin source model and a 1-clock tick.
`timescale 1ns/1ps
`define CHECK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_errors++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end

module led_sink_flash_control_test;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [9:0] address = 10'h000;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [3:0] byteenable = 4'hf;
    logic hibernate = 1'b0;
    logic [1:0] level_req = 2'b00;
    logic [31:0] readdata;
    logic waitrequest;
    logic pin_a;
    logic pin_b;
    logic a_on;
    logic b_on;
    logic [7:0] a_level;
    logic [7:0] b_level;
    logic [15:0] rd;
    logic [15:0] va;
    logic [15:0] vb;
    int n_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    int t0;

    led_sink_flash_control #(.TICK_CYCLES(1)) uut (.clock(clock), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .flash_trigger_a(pin_a), .flash_trigger_b(pin_b), .hibernate(hibernate),
        .sink_pin_a_on(a_on), .sink_pin_a_level(a_level), .sink_pin_b_on(b_on), .sink_pin_b_level(b_level));
    flash_pin_source pins (.clock(clock), .rst(rst), .level_req(level_req), .pin_a(pin_a), .pin_b(pin_b));

    // ****************************************
    // Clock, timeout and closing
    // ****************************************
    initial begin
        forever #2 clock = ~clock;
    end

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_errors++;
            complete_run();
        end
    end

    task complete_run;
        $display("Counts: %0d compares, %0d mismatches", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ****************************************
    // Bus and wait helpers
    // ****************************************
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [15:0] wd);
        @(posedge clock);
        address <= {idx, 2'b00};
        writedata <= {16'h0000, wd};
        write <= wr;
        read <= !wr;
        // Only the cycle ceiling ends a wait that never gets its answer
        do begin
            @(posedge clock);
        end while (waitrequest !== 1'b0);
        rd = readdata[15:0];
        write <= 1'b0;
        read <= 1'b0;
    endtask

    task automatic wait_on(input logic ch, input logic lvl);
        while ((ch ? b_on : a_on) !== lvl) begin
            @(posedge clock);
        end
    endtask

    function automatic int dur_exp(input logic [1:0] code);
        case (code)
            2'b00: dur_exp = 32000;
            2'b01: dur_exp = 64000;
            2'b10: dur_exp = 96000;
            default: dur_exp = 1024000;
        endcase
    endfunction

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        void'($urandom(22944));
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        xfer(0, led_flash_pkg::IDX_A_CTRL, 0); `CHECK("ctrl a reset", 16'h0000, rd)
        xfer(0, led_flash_pkg::IDX_POWER_ENABLE, 0); `CHECK("enable reset", 16'h0000, rd)
        xfer(0, 8'h55, 0); `CHECK("unmapped read", 16'h0000, rd)
        $display("Test reset done");
        repeat (4) begin
            va = 16'($urandom) & led_flash_pkg::CTRL_WRITE_MASK & 16'h5fff;
            vb = 16'($urandom) & led_flash_pkg::CTRL_WRITE_MASK & 16'h5fff;
            xfer(1, led_flash_pkg::IDX_A_CTRL, va);
            xfer(1, led_flash_pkg::IDX_B_CTRL, vb);
            xfer(0, led_flash_pkg::IDX_A_CTRL, 0); `CHECK("ctrl a", va, rd)
            xfer(0, led_flash_pkg::IDX_B_CTRL, 0); `CHECK("ctrl b", vb, rd)
        end
        xfer(1, led_flash_pkg::IDX_B_CTRL, 16'h0000);
        $display("Test registers done");
        xfer(1, led_flash_pkg::IDX_POWER_ENABLE, 16'h0001);
        xfer(1, led_flash_pkg::IDX_A_CTRL, 16'h6000);
        repeat (4) @(posedge clock);
        `CHECK("led a on", 2'b11, {a_on, a_level == 8'hff})
        `CHECK("led b off", 1'b0, b_on)
        xfer(1, led_flash_pkg::IDX_POWER_ENABLE, 16'h0000);
        repeat (3) @(posedge clock);
        `CHECK("led a disabled", 2'b00, {a_on, a_level != 8'h00})
        xfer(1, led_flash_pkg::IDX_A_CURRENT, 16'h8000);
        xfer(0, led_flash_pkg::IDX_POWER_ENABLE, 0); `CHECK("enable alias", 16'h0001, rd)
        hibernate <= 1'b1;
        repeat (5) @(posedge clock);
        `CHECK("hibernate off", 1'b0, a_on)
        hibernate <= 1'b0;
        repeat (3) @(posedge clock);
        xfer(0, led_flash_pkg::IDX_A_CTRL, 0); `CHECK("hibernate exit", 16'h4000, rd)
        xfer(1, led_flash_pkg::IDX_A_CTRL, 16'h6000);
        xfer(0, led_flash_pkg::IDX_A_CTRL, 0); `CHECK("drive restored", 16'h6000, rd)
        $display("Test led mode done");
        xfer(1, led_flash_pkg::IDX_A_CTRL, 16'h8000);
        xfer(1, led_flash_pkg::IDX_A_CTRL, 16'ha000);
        wait_on(0, 1'b1);
        t0 = cyc;
        xfer(0, led_flash_pkg::IDX_A_CTRL, 0); `CHECK("status in flash", 16'ha000, rd)
        wait_on(0, 1'b0);
        `CHECK("reg flash len", 1'b1, (cyc - t0 >= dur_exp(0) - 3 && cyc - t0 <= dur_exp(0) + 3))
        xfer(0, led_flash_pkg::IDX_A_CTRL, 0); `CHECK("drive self clear", 16'h8000, rd)
        repeat (50) @(posedge clock);
        `CHECK("one flash", 1'b0, a_on)
        $display("Test register flash done");
        xfer(1, led_flash_pkg::IDX_POWER_ENABLE, 16'h0003);
        xfer(1, led_flash_pkg::IDX_B_CTRL, 16'hc000);
        xfer(1, led_flash_pkg::IDX_B_CTRL, 16'he000);
        repeat (50) @(posedge clock);
        `CHECK("drive write ignored", 1'b0, b_on)
        level_req <= 2'b10;
        wait_on(1, 1'b1);
        t0 = cyc;
        `CHECK("gpio b level", 8'hff, b_level)
        wait_on(1, 1'b0);
        `CHECK("gpio flash len", 1'b1, (cyc - t0 >= dur_exp(0) - 3 && cyc - t0 <= dur_exp(0) + 3))
        repeat (100) @(posedge clock);
        `CHECK("level no retrigger", 2'b00, {b_on, a_on})
        $display("Test gpio flash done");
        complete_run();
    end
endmodule
